// [include/sioc_map.svh]
/*
  offsets, bit positions, reset values and timing counts of the servo io
  status and control block; assumes a 20 MHz ref_clk on both ends.
*/
`ifndef SIOC_MAP_SVH
`define SIOC_MAP_SVH

// ----------------------------------------
// device offsets on the link (byte address)
// ----------------------------------------
`define SIOC_OFF_STATUS    6'h0c
`define SIOC_OFF_RESULT    6'h1c
`define SIOC_OFF_START     6'h1e
`define SIOC_OFF_CHSEL     6'h2c
`define SIOC_OFF_DOUT      6'h2e

// ----------------------------------------
// discrete output word fields
// ----------------------------------------
`define SIOC_DOUT_RESET    16'h0000
`define SIOC_DOUT_OC_HI    4
`define SIOC_DOUT_PLAIN    5
`define SIOC_DOUT_CAL      6
`define SIOC_DOUT_XBIT     7
`define SIOC_DOUT_IDX_LO   8
`define SIOC_DOUT_IDX_HI   13
`define SIOC_DOUT_CONV     14
`define SIOC_DOUT_RED      15

// ----------------------------------------
// status input word fields
// ----------------------------------------
`define SIOC_STAT_THERM_HI 5
`define SIOC_STAT_CAL      6
`define SIOC_STAT_XBIT     7
`define SIOC_STAT_IDX_LO   8
`define SIOC_STAT_IDX_HI   13
`define SIOC_STAT_CONV     14
`define SIOC_STAT_ARM      15

// ----------------------------------------
// conversion timing
// ----------------------------------------
`define SIOC_CLK_KHZ       20000
`define SIOC_CONV_TIME_MS  128
`define SIOC_CONV_CYCLES   (`SIOC_CONV_TIME_MS * `SIOC_CLK_KHZ)

// ----------------------------------------
// host command port offsets
// ----------------------------------------
`define SIOC_H_ADDR        3'h0
`define SIOC_H_WRITE       3'h1
`define SIOC_H_READ        3'h2
`define SIOC_H_RDATA       3'h3
`define SIOC_H_STATUS      3'h4
`define SIOC_H_CLEAR       3'h5

`endif

// [include/sioc_pkg.sv]
/*
  types shared by the servo io status and control ends; assumes nothing.
*/
package sioc_pkg;

  typedef enum logic [4:0]
  {
    SIOC_H_IDLE  = 5'b0_0001,
    SIOC_H_RSTB  = 5'b0_0010,
    SIOC_H_CAPT  = 5'b0_0100,
    SIOC_H_CLR0  = 5'b0_1000,
    SIOC_H_CLR1  = 5'b1_0000
  } sioc_hstate_t;

  typedef logic [15:0] sioc_word_t;

endpackage : sioc_pkg

// [include/sioc_if.sv]
/*
  address/data link between the bus interface end and the servo io card;
  assumes both ends run on the same ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none

interface sioc_if;
  logic [5:0]         addr;
  sioc_pkg::sioc_word_t wdata;
  logic               wr;
  logic               rd;
  sioc_pkg::sioc_word_t rdata;
  logic               irq;

  modport device
  (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata,
    output irq
  );

  modport host
  (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata,
    input  irq
  );
endinterface : sioc_if

`default_nettype wire

// [logic/sioc_device.sv]
/*
  card end of the servo io status and control block: discrete output word,
  status input word, analog input sequence and interrupt line.
  assumes one 20 MHz ref_clk, the converter sample and board pins arriving
  asynchronously, and the channel 6 counter running on ref_clk.
*/
// What this block does
// (RULE_01) result is 8-bit code, 00h zero, FFh five volts
// (RULE_02) host drops upper byte of result word
// (RULE_03) channel select write routes mux channel
// (RULE_04) read of start offset begins a conversion
// (RULE_05) result readable 128 ms after start
// (RULE_06) enabled end of conversion: status low, irq high
// (RULE_07) polling host clears conversion flag by mask toggle
// (RULE_08) output word whole-word write, never read back
// (RULE_09) bits 0-4 open collector, 5 plain, 15 red
// (RULE_10) reset clears output word to zero
// (RULE_11) bit 6 calibration flag echoes in status 6
// (RULE_12) bit 7 latch presets channel 6 extra bit
// (RULE_13) bits 8-13 enable index interrupts and status
// (RULE_14) bit 14 conversion mask; toggle clears pending
// (RULE_15) status word read only at offset 0Ch
// (RULE_16) enabled index pulse pulls status 8-13 low
// (RULE_17) enabled conversion end pulls status 14 low
// (RULE_18) channel 6 count shows counter bits 1-16
// (RULE_19) status 7 shows jumper-chosen extra bit
// (RULE_20) status 15 arm power, 0-5 thermal overload
// (RULE_21) output bits 0-2 low after reset
// (RULE_22) address bit 0 ignored in decode
// (RULE_23) irq high while any enabled flag pends
`timescale 1ns/1ns
`default_nettype none
`include "sioc_map.svh"

module sioc_device
#(
  parameter int unsigned CONV_CYCLES = `SIOC_CONV_CYCLES
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  sioc_if.device           link,
  input  wire logic [5:0]  thermal_switch,
  input  wire logic        arm_power_on,
  input  wire logic [7:0]  adc_sample,
  input  wire logic [5:0]  index_pulse,
  input  wire logic        extra_bit_position_jumper,
  input  wire logic [17:0] ch6_counter,
  output logic [2:0]       adc_channel,
  output logic             adc_start,
  output logic [4:0]       offboard_oc_out,
  output logic [4:0]       offboard_oc_oe_b,
  output logic             offboard_out5,
  output logic             red_fault_indicator_b,
  output logic             cal_flag,
  output logic             extra_bit_preset,
  output logic [5:0]       index_mask,
  output logic [15:0]      ch6_count_word
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  sioc_pkg::sioc_word_t dout;
  sioc_pkg::sioc_word_t next_dout;
  sioc_pkg::sioc_word_t rdata;
  sioc_pkg::sioc_word_t next_rdata;
  logic [2:0]  next_adc_channel;
  logic        next_adc_start;
  logic [4:0]  next_oc_oe_b;
  logic [15:0] next_ch6_count_word;
  logic [7:0]  result;
  logic [7:0]  next_result;
  logic        conv_busy;
  logic        next_conv_busy;
  logic [31:0] conv_cnt;
  logic [31:0] next_conv_cnt;
  logic [5:0]  idx_pend;
  logic [5:0]  next_idx_pend;
  logic        conv_pend;
  logic        next_conv_pend;
  logic        irq;
  logic        next_irq;
  // synchronisers: stage 1, stage 2, and a third stage for index edges
  logic [13:0] pin_s1;
  logic [13:0] pin_s2;
  logic [7:0]  adc_s1;
  logic [7:0]  adc_s2;
  logic [5:0]  idx_s3;

  logic [5:0]  word_addr;
  logic        wr_dout;
  logic        wr_chsel;
  logic        rd_start;
  logic        conv_end;
  logic [5:0]  idx_edge;
  logic [5:0]  thermal_s;
  logic        arm_s;
  logic        jumper_s;
  logic [5:0]  idx_s;

  assign thermal_s = pin_s2[5:0];
  assign arm_s     = pin_s2[6];
  assign jumper_s  = pin_s2[7];
  assign idx_s     = pin_s2[13:8];

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always_comb
  begin
    word_addr = {link.addr[5:1], 1'b0}; // [RULE_22]
    wr_dout   = link.wr && (word_addr == `SIOC_OFF_DOUT);
    wr_chsel  = link.wr && (word_addr == `SIOC_OFF_CHSEL);
    rd_start  = link.rd && (word_addr == `SIOC_OFF_START); // [RULE_04]
    conv_end = conv_busy && (conv_cnt == CONV_CYCLES - 32'd1);      // [RULE_05]
    idx_edge = idx_s & ~idx_s3;

    next_dout = dout;
    if (wr_dout)
    begin
      next_dout = link.wdata;                                       // [RULE_08]
    end
    next_oc_oe_b = ~next_dout[`SIOC_DOUT_OC_HI:0];                  // [RULE_09]

    next_adc_channel = adc_channel;
    if (wr_chsel)
    begin
      next_adc_channel = link.wdata[2:0];                           // [RULE_03]
    end
    next_adc_start = rd_start;

    next_conv_busy = conv_busy;
    next_conv_cnt  = conv_cnt;
    next_result    = result;
    if (rd_start)
    begin
      next_conv_busy = 1'b1;
      next_conv_cnt  = 32'd0;
    end
    else if (conv_end)
    begin
      next_conv_busy = 1'b0;
      next_result    = adc_s2;                                      // [RULE_01]
    end
    else if (conv_busy)
    begin
      next_conv_cnt = conv_cnt + 32'd1;
    end

    // a mask at zero clears the flag and wins over an event; an enabled event sets it
    next_idx_pend = (idx_pend | idx_edge) & index_mask; // [RULE_13] [RULE_16]
    next_conv_pend = (conv_pend | conv_end)             // [RULE_06] [RULE_17]
                   & dout[`SIOC_DOUT_CONV];             // [RULE_14]
    next_irq = (|idx_pend) | conv_pend;                             // [RULE_23]

    next_ch6_count_word = ch6_counter[16:1];                        // [RULE_18]

    next_rdata = 16'h0000;
    if (link.rd)
    begin
      if (word_addr == `SIOC_OFF_STATUS) // [RULE_15]
      begin
        next_rdata[`SIOC_STAT_THERM_HI:0] = thermal_s;              // [RULE_20]
        next_rdata[`SIOC_STAT_CAL]  = dout[`SIOC_DOUT_CAL];         // [RULE_11]
        next_rdata[`SIOC_STAT_XBIT] = jumper_s ? ch6_counter[17]
                                               : ch6_counter[0];    // [RULE_19]
        next_rdata[`SIOC_STAT_IDX_HI:`SIOC_STAT_IDX_LO] = ~idx_pend; // [RULE_16]
        next_rdata[`SIOC_STAT_CONV] = ~conv_pend;                   // [RULE_06]
        next_rdata[`SIOC_STAT_ARM]  = arm_s;                        // [RULE_20]
      end
      else if (word_addr == `SIOC_OFF_RESULT)
      begin
        next_rdata = {8'h00, result};                               // [RULE_01]
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dout           <= `SIOC_DOUT_RESET; // [RULE_10] [RULE_21]
      offboard_oc_oe_b <= 5'h1f;
      adc_channel    <= 3'h0;
      adc_start      <= 1'b0;
      result         <= 8'h00;
      conv_busy      <= 1'b0;
      conv_cnt       <= 32'd0;
      idx_pend       <= 6'h00;
      conv_pend      <= 1'b0;
      irq            <= 1'b0;
      rdata          <= 16'h0000;
      ch6_count_word <= 16'h0000;
      pin_s1         <= 14'h0000;
      pin_s2         <= 14'h0000;
      adc_s1         <= 8'h00;
      adc_s2         <= 8'h00;
      idx_s3         <= 6'h00;
    end
    else
    begin
      dout           <= next_dout;
      offboard_oc_oe_b <= next_oc_oe_b;
      adc_channel    <= next_adc_channel;
      adc_start      <= next_adc_start;
      result         <= next_result;
      conv_busy      <= next_conv_busy;
      conv_cnt       <= next_conv_cnt;
      idx_pend       <= next_idx_pend;
      conv_pend      <= next_conv_pend;
      irq            <= next_irq;
      rdata          <= next_rdata;
      ch6_count_word <= next_ch6_count_word;
      pin_s1         <= {index_pulse, extra_bit_position_jumper,
                         arm_power_on, thermal_switch};
      pin_s2         <= pin_s1;
      adc_s1         <= adc_sample;
      adc_s2         <= adc_s1;
      idx_s3         <= idx_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign link.rdata            = rdata;
  assign link.irq              = irq;
  assign offboard_oc_out       = 5'h00;
  assign offboard_out5         = dout[`SIOC_DOUT_PLAIN];             // [RULE_09]
  assign red_fault_indicator_b = dout[`SIOC_DOUT_RED];               // [RULE_09]
  assign cal_flag              = dout[`SIOC_DOUT_CAL];               // [RULE_11]
  assign extra_bit_preset      = dout[`SIOC_DOUT_XBIT];              // [RULE_12]
  assign index_mask            = dout[`SIOC_DOUT_IDX_HI:`SIOC_DOUT_IDX_LO];

endmodule : sioc_device

`default_nettype wire

// [logic/sioc_host.sv]
/*
  bus interface end of the servo io link: turns command port orders into
  link transfers, keeps a shadow of the write-only output word for the
  mask toggle, and times conversions. assumes the same ref_clk as the card.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sioc_map.svh"

module sioc_host
#(
  parameter int unsigned CONV_CYCLES = `SIOC_CONV_CYCLES
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  sioc_if.host             link,
  input  wire logic [2:0]  cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  output logic [15:0]      cmd_rdata
);

  sioc_pkg::sioc_hstate_t state;
  sioc_pkg::sioc_hstate_t next_state;
  logic [5:0]  tgt;
  logic [5:0]  next_tgt;
  logic [15:0] shadow;
  logic [15:0] next_shadow;
  logic [15:0] clr_bits;
  logic [15:0] next_clr_bits;
  logic [15:0] rd_data;
  logic [15:0] next_rd_data;
  logic [15:0] next_cmd_rdata;
  logic [5:0]  l_addr;
  logic [5:0]  next_l_addr;
  logic [15:0] l_wdata;
  logic [15:0] next_l_wdata;
  logic        l_wr;
  logic        next_l_wr;
  logic        l_rd;
  logic        next_l_rd;
  logic [31:0] wait_cnt;
  logic [31:0] next_wait_cnt;
  logic        conv_ready;
  logic        next_conv_ready;
  logic        idle;

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always_comb
  begin
    idle            = (state == sioc_pkg::SIOC_H_IDLE);
    next_state      = state;
    next_tgt        = tgt;
    next_shadow     = shadow;
    next_clr_bits   = clr_bits;
    next_rd_data    = rd_data;
    next_l_addr     = l_addr;
    next_l_wdata    = l_wdata;
    next_l_wr       = 1'b0;
    next_l_rd       = 1'b0;
    next_wait_cnt   = wait_cnt;
    next_conv_ready = conv_ready;
    if (!conv_ready && wait_cnt != 32'd0)
    begin
      next_wait_cnt = wait_cnt - 32'd1;
      next_conv_ready = (wait_cnt == 32'd1);                        // [RULE_05]
    end

    unique case (state)
      sioc_pkg::SIOC_H_IDLE:
      begin
        if (cmd_wr && cmd_addr == `SIOC_H_ADDR)
        begin
          next_tgt = {cmd_wdata[5:1], 1'b0};                        // [RULE_22]
        end
        else if (cmd_wr && cmd_addr == `SIOC_H_WRITE)
        begin
          next_l_wr    = 1'b1;
          next_l_addr  = tgt;                                       // [RULE_03]
          next_l_wdata = cmd_wdata;                                 // [RULE_08]
          if (tgt == `SIOC_OFF_DOUT)
          begin
            next_shadow = cmd_wdata;
          end
        end
        else if (cmd_wr && cmd_addr == `SIOC_H_READ)
        begin
          next_l_rd   = 1'b1;
          next_l_addr = tgt;
          next_state  = sioc_pkg::SIOC_H_RSTB;
          if (tgt == `SIOC_OFF_START)
          begin
            next_conv_ready = 1'b0;                                 // [RULE_04]
            next_wait_cnt   = CONV_CYCLES;
          end
        end
        else if (cmd_wr && cmd_addr == `SIOC_H_CLEAR)
        begin
          next_clr_bits = cmd_wdata;
          next_state    = sioc_pkg::SIOC_H_CLR0;
        end
      end
      sioc_pkg::SIOC_H_RSTB:
      begin
        next_state = sioc_pkg::SIOC_H_CAPT;
      end
      sioc_pkg::SIOC_H_CAPT:
      begin
        next_rd_data = link.rdata;
        if (tgt == `SIOC_OFF_RESULT)
        begin
          next_rd_data = {8'h00, link.rdata[7:0]};                  // [RULE_02]
        end
        next_state = sioc_pkg::SIOC_H_IDLE;
      end
      sioc_pkg::SIOC_H_CLR0:
      begin
        next_l_wr    = 1'b1;
        next_l_addr  = `SIOC_OFF_DOUT;
        next_l_wdata = shadow & ~clr_bits; // [RULE_07] [RULE_14]
        next_state   = sioc_pkg::SIOC_H_CLR1;
      end
      sioc_pkg::SIOC_H_CLR1:
      begin
        next_l_wr    = 1'b1;
        next_l_wdata = shadow;                                      // [RULE_14]
        next_state   = sioc_pkg::SIOC_H_IDLE;
      end
    endcase

    next_cmd_rdata = 16'h0000;
    if (cmd_rd && cmd_addr == `SIOC_H_RDATA)
    begin
      next_cmd_rdata = rd_data;
    end
    else if (cmd_rd && cmd_addr == `SIOC_H_STATUS)
    begin
      next_cmd_rdata = {13'h0000, conv_ready, link.irq, !idle};
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state      <= sioc_pkg::SIOC_H_IDLE;
      tgt        <= 6'h00;
      shadow     <= `SIOC_DOUT_RESET;
      clr_bits   <= 16'h0000;
      rd_data    <= 16'h0000;
      cmd_rdata  <= 16'h0000;
      l_addr     <= 6'h00;
      l_wdata    <= 16'h0000;
      l_wr       <= 1'b0;
      l_rd       <= 1'b0;
      wait_cnt   <= 32'd0;
      conv_ready <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      tgt        <= next_tgt;
      shadow     <= next_shadow;
      clr_bits   <= next_clr_bits;
      rd_data    <= next_rd_data;
      cmd_rdata  <= next_cmd_rdata;
      l_addr     <= next_l_addr;
      l_wdata    <= next_l_wdata;
      l_wr       <= next_l_wr;
      l_rd       <= next_l_rd;
      wait_cnt   <= next_wait_cnt;
      conv_ready <= next_conv_ready;
    end
  end

  assign link.addr  = l_addr;
  assign link.wdata = l_wdata;
  assign link.wr    = l_wr;
  assign link.rd    = l_rd;

endmodule : sioc_host

`default_nettype wire

// [sim/sioc_checker.sv]
/*
  link checker for the servo io status and control block.
  assumes it sees the link signals as plain inputs, all on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none

module sioc_checker
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [5:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // helper state: last mask, all-masks-off and clear counts
  // ----------------------------------------
  logic       dout_wr;
  logic [6:0] mask_q;
  logic [6:0] next_mask_q;
  logic [2:0] off_cnt;
  logic [2:0] next_off_cnt;
  logic [2:0] clr_cnt;
  logic [2:0] next_clr_cnt;

  assign dout_wr = wr && addr[5:1] == 5'h17;

  always_comb
  begin
    next_mask_q  = dout_wr ? wdata[14:8] : mask_q;
    next_off_cnt = off_cnt;
    next_clr_cnt = clr_cnt;
    if (mask_q != 7'h00)
      next_off_cnt = 3'd0;
    else if (off_cnt != 3'd4)
      next_off_cnt = off_cnt + 3'd1;
    if (dout_wr && wdata[14:8] != 7'h7f)
      next_clr_cnt = 3'd0;
    else if (clr_cnt != 3'd7)
      next_clr_cnt = clr_cnt + 3'd1;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mask_q  <= 7'h00;
      off_cnt <= 3'd4;
      clr_cnt <= 3'd7;
    end
    else
    begin
      mask_q  <= next_mask_q;
      off_cnt <= next_off_cnt;
      clr_cnt <= next_clr_cnt;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_strobes_excl: assert property (!(wr && rd))
    else $error("write and read strobe together");
  a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data without a read");
  a_start_data: assert property
    (rd && addr[5:1] == 5'h0f |=> rdata == 16'h0000)
    else $error("start read returned data");
  a_wo_data: assert property
    (rd && addr[5:1] == 5'h17 |=> rdata == 16'h0000)
    else $error("output word read back");
  a_result_byte: assert property
    (rd && addr[5:1] == 5'h0e |=> rdata[15:8] == 8'h00)
    else $error("result upper byte not zero");
  a_mask_off_irq: assert property
    (dout_wr && wdata[14:8] == 7'h00 |-> ##3 !irq)
    else $error("irq stays after all masks off");
  a_irq_masked: assert property (off_cnt == 3'd4 |-> !irq)
    else $error("irq while every mask is off");
  a_irq_fall: assert property ($fell(irq) |-> clr_cnt <= 3'd5)
    else $error("irq fell without a mask toggle");
  a_irq_rise: assert property ($rose(irq) |-> $past(mask_q, 2) != 7'h00)
    else $error("irq rose with no mask enabled");
endmodule : sioc_checker

`default_nettype wire

// [sim/testbench.sv]
/*
  testbench for both ends of the servo io link: drives the host command
  port and the card pins. assumes 20 MHz ref_clk, short conversion time.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
  localparam int CONV = 20;
  logic        ref_clk;
  logic        rst_b;
  logic [2:0]  cmd_addr;
  logic [15:0] cmd_wdata;
  logic        cmd_wr;
  logic        cmd_rd;
  logic [15:0] cmd_rdata;
  logic [5:0]  therm;
  logic        arm;
  logic [7:0]  sample;
  logic [5:0]  idx;
  logic        jumper;
  logic [17:0] cnt6;
  logic [2:0]  chan;
  logic        adc_start;
  logic [4:0]  oe_b;
  logic        out5;
  logic        red_b;
  logic        cal;
  logic        xbit;
  logic [5:0]  imask;
  logic [15:0] word6;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          starts = 0;

  sioc_if link();
  sioc_device #(.CONV_CYCLES(CONV)) i_sioc_device
  (
    .ref_clk(ref_clk), .rst_b(rst_b), .link(link), .thermal_switch(therm),
    .arm_power_on(arm), .adc_sample(sample), .index_pulse(idx),
    .extra_bit_position_jumper(jumper), .ch6_counter(cnt6),
    .adc_channel(chan), .adc_start(adc_start), .offboard_oc_out(),
    .offboard_oc_oe_b(oe_b), .offboard_out5(out5),
    .red_fault_indicator_b(red_b), .cal_flag(cal), .extra_bit_preset(xbit),
    .index_mask(imask), .ch6_count_word(word6)
  );
  sioc_host #(.CONV_CYCLES(CONV)) i_sioc_host
  (
    .ref_clk(ref_clk), .rst_b(rst_b), .link(link), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_rdata(cmd_rdata)
  );
  sioc_checker i_sioc_checker
  (
    .ref_clk(ref_clk), .rst_b(rst_b), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .irq(link.irq)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
    if (adc_start === 1'b1)
      starts++;

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic order(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    cmd_addr  <= a;
    cmd_wdata <= d;
    cmd_wr    <= 1'b1;
    @(posedge ref_clk);
    cmd_wr <= 1'b0;
  endtask : order

  task automatic fetch(input logic [2:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    cmd_addr <= a;
    cmd_rd   <= 1'b1;
    @(posedge ref_clk);
    cmd_rd <= 1'b0;
    #1 d = cmd_rdata;
  endtask : fetch

  task automatic wait_idle();
    logic [15:0] s;
    for (int i = 0; i < 20; i++)
    begin
      fetch(3'h4, s);
      if (s[0] === 1'b0)
        return;
    end
    n_mismatch++;
    test_done();
  endtask : wait_idle

  task automatic link_wr(input logic [5:0] off, input logic [15:0] d);
    order(3'h0, {10'h000, off});
    order(3'h1, d);
    repeat (4) @(posedge ref_clk);
  endtask : link_wr

  task automatic link_rd(input logic [5:0] off, output logic [15:0] d);
    order(3'h0, {10'h000, off});
    order(3'h2, 16'h0000);
    wait_idle();
    fetch(3'h3, d);
  endtask : link_rd

  task automatic link_clear(input logic [15:0] bits);
    order(3'h5, bits);
    wait_idle();
    repeat (4) @(posedge ref_clk);
  endtask : link_clear

  function automatic logic [15:0] pins();
    return {1'b0, red_b, out5, cal, xbit, oe_b, imask};
  endfunction : pins

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [15:0] s;
    check("pins", 16'h07c0, pins());
    check("irq", 16'h0000, {15'h0, link.irq});
    link_rd(6'h0c, s);
    check("status", 16'hff2a, s);
  endtask : t_reset

  task automatic t_outputs();
    logic [15:0] w [2] = '{16'hc0e5, 16'h3f1a};
    logic [15:0] s;
    foreach (w[k])
    begin
      therm <= w[k][13:8];
      arm   <= w[k][0];
      link_wr(6'h2e, w[k]);
      check("pins", {1'b0, w[k][15], w[k][5], w[k][6],
                     w[k][7], ~w[k][4:0], w[k][13:8]}, pins());
      link_rd(6'h2e, s);
      check("dout read", 16'h0000, s);
      link_rd(6'h0e, s);
      check("unmapped", 16'h0000, s);
      link_rd(6'h0d, s);
      check("status", {w[k][0], 7'h7f, 1'b0, w[k][6],
                       w[k][13:8]}, s);
    end
    link_wr(6'h2e, 16'h0000);
  endtask : t_outputs

  task automatic t_extra();
    logic [15:0] s;
    cnt6 <= 18'h2_a5a4;
    for (int j = 0; j < 2; j++)
    begin
      jumper <= j[0];
      link_rd(6'h0c, s);
      check("xbit", {15'h0, j[0] ? cnt6[17] : cnt6[0]},
            {15'h0, s[7]});
    end
    check("count6", cnt6[16:1], word6);
  endtask : t_extra

  task automatic t_conv();
    logic [15:0] s;
    int          n0;
    int          i;
    for (int m = 0; m < 2; m++)
    begin
      link_wr(6'h2c, 16'h0003 + m[15:0]);
      check("chan", {13'h0, 3'd3 + m[2:0]}, {13'h0, chan});
      link_wr(6'h2e, {1'b0, m[0], 14'h0000});
      sample <= {8{m[0]}};
      n0 = starts;
      link_rd(6'h1e, s);
      check("start data", 16'h0000, s);
      check("starts", 16'h0001, 16'(starts - n0));
      repeat (CONV / 4) @(posedge ref_clk);
      check("early irq", 16'h0000, {15'h0, link.irq});
      fetch(3'h4, s);
      check("early ready", 16'h0000, {15'h0, s[2]});
      for (i = 0; i < 4 * CONV && link.irq !== m[0]; i++)
        @(posedge ref_clk);
      if (i == 4 * CONV)
      begin
        n_mismatch++;
        test_done();
      end
      repeat (CONV) @(posedge ref_clk);
      check("irq", {15'h0, m[0]}, {15'h0, link.irq});
      fetch(3'h4, s);
      check("ready irq", {13'h0, 1'b1, m[0], 1'b0}, s);
      link_rd(6'h1c, s);
      check("result", {8'h00, {8{m[0]}}}, s);
      link_rd(6'h0c, s);
      check("conv status", {15'h0, ~m[0]}, {15'h0, s[14]});
      link_clear(16'h4000);
      link_rd(6'h0c, s);
      check("conv clear", 16'h0001, {15'h0, s[14]});
      check("irq clear", 16'h0000, {15'h0, link.irq});
    end
  endtask : t_conv

  task automatic t_index();
    logic [15:0] s;
    logic [15:0] bits [2] = '{16'h0100, 16'h0400};
    logic [5:0]  pend [2] = '{6'h3b, 6'h3f};
    link_wr(6'h2e, 16'h0500);
    idx <= 6'h3f;
    repeat (4) @(posedge ref_clk);
    idx <= 6'h00;
    repeat (4) @(posedge ref_clk);
    link_rd(6'h0c, s);
    check("index status", 16'h003a, {10'h0, s[13:8]});
    check("index irq", 16'h0001, {15'h0, link.irq});
    foreach (bits[k])
    begin
      link_clear(bits[k]);
      link_rd(6'h0c, s);
      check("index clear", {10'h0, pend[k]}, {10'h0, s[13:8]});
      check("irq", {15'h0, ~k[0]}, {15'h0, link.irq});
    end
  endtask : t_index

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst_b     = 1'b0;
    cmd_addr  = 3'h0;
    cmd_wdata = 16'h0000;
    cmd_wr    = 1'b0;
    cmd_rd    = 1'b0;
    therm     = 6'h2a;
    arm       = 1'b1;
    sample    = 8'h00;
    idx       = 6'h00;
    jumper    = 1'b0;
    cnt6      = 18'h0_0000;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_outputs();
    t_extra();
    t_conv();
    t_index();
    test_done();
  end
endmodule : testbench

`default_nettype wire
